// >>> rtl/sfsi_flash_dev.sv
// flash device end: pin sampling, instruction decode, array and internal cycles
// assumes link pins are asynchronous to pclk; all are synchronised here
// Summary of operation
// - sample data in on clock rise
// - data out changes after clock fall
// - deselected: output released
// - standby only when no internal cycle
// - select low makes device active
// - ignore everything before first select fall
// - pause keeps partial instruction state
// - paused: output released, clock ignored
// - master pauses only while selected
// - write protect freezes protect bits; here only while SRWD is set
// - modes 0 and 3 both work
// - clock idles low or high
// - enable, then page write, then cycle
// - up to 256 bytes within one page
// - erase sector or array to FF
// - erase needs prior write enable
// - busy bit set during internal cycles
// - 16 sectors, 256 pages, 256 bytes
// - master drives protect and pause pins
// - write enable latch cleared on completion
// - writes need whole bytes before deselect
// - pause changes only while clock low
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sfsi_flash_dev
   import sfsi_pkg::*;
#(
   parameter int SE_LEN = SECTOR_BYTES,
   parameter int BE_LEN = MEM_BYTES
) (
   // system
   input  wire logic pclk,
   input  wire logic presetn,
   // link
   sfsi_link_if.dev  link,
   // user side
   output logic      standby,
   output logic      busy
);

   typedef struct packed {
      logic [4:0]        s1;
      logic [4:0]        s2;
      logic              sclk_d;
      logic              csn_d;
      logic              seen_fall;
      logic              paused;
      logic [2:0]        bitcnt;
      logic [2:0]        bytecnt;
      logic [7:0]        shin;
      logic [7:0]        opcode;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        sr_new;
      logic              reading;
      logic [7:0]        shout;
      logic              miso;
      logic              write_enable_latch;
      logic [2:0]        bp;
      logic              srwd;
      sfsi_op_t          op;
      logic [ADDR_W-1:0] wcnt;
      logic [ADDR_W-1:0] wlast;
      logic [ADDR_W-1:0] wbase;
      logic [PAGE_BYTES-1:0] pvalid;
   } sfsi_dev_state_t;

   localparam sfsi_dev_state_t DEV_RST = '{s1: PIN_IDLE, s2: PIN_IDLE, csn_d: 1'b1,
                                           op: OP_IDLE, default: '0};

   sfsi_dev_state_t   r;
   sfsi_dev_state_t   n;
   logic [4:0]        pins;
   logic              selected;
   logic              rise;
   logic              fall;
   logic              cs_rise;
   logic              busy_i;
   logic [7:0]        byte_in;
   logic [7:0]        status_byte;
   logic [ADDR_W-1:0] walk_addr;
   logic [ADDR_W-1:0] load_addr;
   logic [ADDR_W-1:0] rd_addr;
   logic [7:0]        mem_rd;
   logic [7:0]        pbuf_rd;
   logic              mem_we;
   logic [7:0]        mem_wd;
   logic              buf_we;
   logic [7:0]        mem [MEM_BYTES];
   logic [7:0]        pbuf [PAGE_BYTES];

   // pin vector and edge detection on the synchronised copies
   assign pins        = {link.wp_n, link.hold_n, link.mosi, link.cs_n, link.sclk};
   assign selected    = !r.s2[PIN_CSN] && r.seen_fall;
   assign rise        = selected && !r.paused && r.s2[PIN_SCLK] && !r.sclk_d;
   assign fall        = selected && !r.paused && !r.s2[PIN_SCLK] && r.sclk_d;
   assign cs_rise     = r.s2[PIN_CSN] && !r.csn_d && r.seen_fall;
   assign busy_i      = (r.op != OP_IDLE);
   assign byte_in     = {r.shin[6:0], r.s2[PIN_MOSI]};
   assign status_byte = {r.srwd, 2'b00, r.bp, r.write_enable_latch, busy_i};

   // one read port, shared by the walk and serial reads (never both at once)
   assign walk_addr = r.wbase + r.wcnt;
   assign load_addr = (r.bytecnt == 3'd3) ? {r.addr[11:0], byte_in} : r.addr;
   assign rd_addr   = busy_i ? walk_addr : load_addr;
   assign mem_rd    = mem[rd_addr];
   assign pbuf_rd   = pbuf[r.wcnt[7:0]];

   // outputs
   assign link.miso_o  = r.miso;
   assign link.miso_oe = r.reading && selected && !r.paused;
   assign standby      = r.s2[PIN_CSN] && !busy_i;
   assign busy         = busy_i;

   // next state
   always_comb begin
      n      = r;
      mem_we = 1'b0;
      mem_wd = ERASED;
      buf_we = 1'b0;
      n.s1     = pins;
      n.s2     = r.s1;
      n.sclk_d = r.s2[PIN_SCLK];
      n.csn_d  = r.s2[PIN_CSN];

      // first select fall arms the device
      if (r.csn_d && !r.s2[PIN_CSN]) begin
         n.seen_fall = 1'b1;
      end

      // pause entry and exit only while the clock is low
      if (!selected) begin
         n.paused = 1'b0;
      end else if (!r.s2[PIN_SCLK]) begin
         n.paused = !r.s2[PIN_HOLDN];
      end

      // serial input: one bit per rising edge
      if (rise) begin
         n.shin   = byte_in;
         n.bitcnt = r.bitcnt + 3'd1;
         if (r.bitcnt == 3'd7) begin
            if (r.bytecnt != 3'd7) begin
               n.bytecnt = r.bytecnt + 3'd1;
            end
            if (r.bytecnt == 3'd0) begin
               n.opcode = byte_in;
               if (byte_in == OPC_STATUS_READ) begin
                  n.reading = 1'b1;
                  n.shout   = status_byte;
               end
               if (byte_in == OPC_PAGE_WRITE && !busy_i) begin
                  n.pvalid = '0;
               end
            end else if (r.bytecnt <= 3'd3) begin
               n.addr = {r.addr[11:0], byte_in};
               if (r.opcode == OPC_STATUS_WRITE && r.bytecnt == 3'd1) begin
                  n.sr_new = byte_in;
               end
               if (r.opcode == OPC_READ && r.bytecnt == 3'd3 && !busy_i) begin
                  n.reading = 1'b1;
                  n.shout   = mem_rd;
                  n.addr    = load_addr + 20'h00001;
               end
            end else if (r.opcode == OPC_PAGE_WRITE && !busy_i) begin
               buf_we                = 1'b1;
               n.pvalid[r.addr[7:0]] = 1'b1;
               n.addr[7:0]           = r.addr[7:0] + 8'h01;
            end
            // refill the output byte at each later byte boundary
            if (r.reading) begin
               if (r.opcode == OPC_STATUS_READ) begin
                  n.shout = status_byte;
               end else begin
                  n.shout = mem_rd;
                  n.addr  = r.addr + 20'h00001;
               end
            end
         end
      end

      // serial output: next bit after each falling edge
      if (fall && r.reading) begin
         n.miso  = r.shout[7];
         n.shout = {r.shout[6:0], 1'b0};
      end

      // deselect resets the instruction state
      if (r.s2[PIN_CSN]) begin
         n.bitcnt  = 3'd0;
         n.bytecnt = 3'd0;
         n.reading = 1'b0;
      end

      // accept writes at deselect on a whole byte count only
      if (cs_rise && !busy_i && r.bitcnt == 3'd0) begin
         n.wcnt = '0;
         unique case (r.opcode)
            OPC_WRITE_ENABLE: begin
               if (r.bytecnt == 3'd1) n.write_enable_latch = 1'b1;
            end
            OPC_WRITE_DISABLE: begin
               if (r.bytecnt == 3'd1) n.write_enable_latch = 1'b0;
            end
            OPC_STATUS_WRITE: begin
               if (r.bytecnt == 3'd2 && r.write_enable_latch && !(r.srwd && !r.s2[PIN_WPN])) begin
                  n.op    = OP_SRW;
                  n.wlast = ADDR_W'(SRW_CYCLES - 1);
               end
            end
            OPC_PAGE_WRITE: begin
               if (r.bytecnt >= 3'd5 && r.write_enable_latch) begin
                  n.op    = OP_PROG;
                  n.wbase = {r.addr[19:8], 8'h00};
                  n.wlast = ADDR_W'(PAGE_BYTES - 1);
               end
            end
            OPC_SECTOR_CLEAR: begin
               if (r.bytecnt == 3'd4 && r.write_enable_latch) begin
                  n.op    = OP_SERASE;
                  n.wbase = {r.addr[19:16], 16'h0000};
                  n.wlast = ADDR_W'(SE_LEN - 1);
               end
            end
            OPC_ARRAY_CLEAR: begin
               if (r.bytecnt == 3'd1 && r.write_enable_latch) begin
                  n.op    = OP_BERASE;
                  n.wbase = '0;
                  n.wlast = ADDR_W'(BE_LEN - 1);
               end
            end
            default: begin
            end
         endcase
      end

      // internal cycle: one byte or step per clock
      if (busy_i) begin
         unique case (r.op)
            OP_PROG: begin
               mem_we = r.pvalid[r.wcnt[7:0]];
               mem_wd = mem_rd & pbuf_rd;
            end
            OP_SERASE, OP_BERASE: begin
               mem_we = 1'b1;
            end
            OP_SRW: begin
               if (r.wcnt == r.wlast) begin
                  n.bp   = r.sr_new[SR_BP0+2:SR_BP0];
                  n.srwd = r.sr_new[SR_SRWD];
               end
            end
            default: begin
            end
         endcase
         n.wcnt = r.wcnt + 20'h00001;
         if (r.wcnt == r.wlast) begin
            n.op  = OP_IDLE;
            n.write_enable_latch = 1'b0;
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= DEV_RST;
      end else begin
         r <= n;
      end
   end

   // array and page buffer, no reset (non-volatile contents)
   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem[walk_addr] <= mem_wd;
      end
      if (buf_we) begin
         pbuf[r.addr[7:0]] <= byte_in;
      end
   end

endmodule
`default_nettype wire

// >>> inc/sfsi_pkg.sv
// shared constants and types for the serial flash link: both ends and the bench
// assumes nothing of its surroundings
package sfsi_pkg;

   // array geometry
   localparam int PAGE_BYTES        = 256;
   localparam int PAGES_PER_SECTOR  = 256;
   localparam int SECTORS           = 16;
   localparam int SECTOR_BYTES      = PAGE_BYTES * PAGES_PER_SECTOR;
   localparam int MEM_BYTES         = SECTOR_BYTES * SECTORS;
   localparam int ADDR_W            = 20;
   localparam logic [7:0] ERASED    = 8'hFF;

   // instruction codes
   localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OPC_STATUS_READ   = 8'h05;
   localparam logic [7:0] OPC_STATUS_WRITE  = 8'h01;
   localparam logic [7:0] OPC_READ          = 8'h03;
   localparam logic [7:0] OPC_PAGE_WRITE    = 8'h02;
   localparam logic [7:0] OPC_SECTOR_CLEAR  = 8'hD8;
   localparam logic [7:0] OPC_ARRAY_CLEAR   = 8'hC7;

   // status byte fields
   localparam int SR_BUSY = 0;
   localparam int SR_WEL  = 1;
   localparam int SR_BP0  = 2;
   localparam int SR_SRWD = 7;
   localparam int SRW_CYCLES = 16;

   // synchronised pin vector: positions and idle value
   localparam int PIN_SCLK  = 0;
   localparam int PIN_CSN   = 1;
   localparam int PIN_MOSI  = 2;
   localparam int PIN_HOLDN = 3;
   localparam int PIN_WPN   = 4;
   localparam logic [4:0] PIN_IDLE = 5'h1A;

   // host register offsets and reset values
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TX   = 8'h04;
   localparam logic [7:0] REG_RX   = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   localparam logic [3:0] CTRL_RST = 4'h8;
   localparam int HOST_HALF_CYCLES = 8;
   localparam int HALF_BITS        = 16;

   // internal cycle kinds
   typedef enum logic [2:0] {
      OP_IDLE   = 3'b000,
      OP_PROG   = 3'b001,
      OP_SERASE = 3'b010,
      OP_BERASE = 3'b011,
      OP_SRW    = 3'b100
   } sfsi_op_t;

endpackage

// >>> inc/sfsi_link_if.sv
// link between the flash device end and the bus master end
// assumes both ends run on their own pclk; the data-out line is resolved here
`timescale 1ns/1ps
`default_nettype none
interface sfsi_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic hold_n;
   logic wp_n;
   logic miso_o;
   logic miso_oe;
   wire  miso;

   // released line reads as pulled high
   assign miso = miso_oe ? miso_o : 1'b1;

   modport dev (input sclk, cs_n, mosi, hold_n, wp_n, output miso_o, miso_oe);
   modport host (output sclk, cs_n, mosi, hold_n, wp_n, input miso);
endinterface
`default_nettype wire

// >>> rtl/sfsi_spi_host.sv
// bus master end: APB register slave driving byte exchanges on the link
// assumes software sequences select, instruction, address and data bytes
`timescale 1ns/1ps
`default_nettype none
module sfsi_spi_host
   import sfsi_pkg::*;
#(
   parameter int HALF_CYCLES = HOST_HALF_CYCLES
) (
   // system
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // link
   sfsi_link_if.host        link
);

   typedef struct packed {
      logic        cs;
      logic        cpol;
      logic        hold_req;
      logic        wp;
      logic        xbusy;
      logic [4:0]  hcnt;
      logic [7:0]  div;
      logic        sclk;
      logic        mosi;
      logic [7:0]  sh;
      logic [7:0]  rx;
      logic        m1;
      logic        m2;
      logic [31:0] rdata;
      logic        err;
   } sfsi_host_state_t;

   localparam sfsi_host_state_t HOST_RST = '{wp: CTRL_RST[3], default: '0};

   sfsi_host_state_t r;
   sfsi_host_state_t n;
   logic             wr;

   assign wr      = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign prdata  = r.rdata;
   assign pslverr = r.err;

   // link pins from flops, hold_n gated with select; pause only while selected
   assign link.sclk   = r.sclk;
   assign link.cs_n   = !r.cs;
   assign link.mosi   = r.mosi;
   assign link.hold_n = !(r.hold_req && r.cs);
   assign link.wp_n   = r.wp;

   always_comb begin
      n    = r;
      n.m1 = link.miso;
      n.m2 = r.m1;

      // setup phase: decode and latch read data
      if (psel && !penable) begin
         n.err   = 1'b0;
         n.rdata = '0;
         unique case (paddr)
            REG_CTRL: n.rdata = {28'h0, r.wp, r.hold_req, r.cpol, r.cs};
            REG_TX:   n.rdata = '0;
            REG_RX:   n.rdata = {24'h0, r.rx};
            REG_STAT: n.rdata = {30'h0, !r.cs, r.xbusy};
            default:  n.err   = 1'b1;
         endcase
      end

      // access phase: writes ignored while an exchange runs
      if (wr && !r.xbusy) begin
         if (paddr == REG_CTRL) begin
            n.cs       = pwdata[0];
            n.cpol     = pwdata[1];
            n.hold_req = pwdata[2];
            n.wp       = pwdata[3];
            n.sclk     = pwdata[1];
         end else if (paddr == REG_TX && r.cs) begin
            n.xbusy = 1'b1;
            n.hcnt  = '0;
            n.div   = '0;
            if (!r.cpol) begin
               n.mosi = pwdata[7];
               n.sh   = {pwdata[6:0], 1'b0};
            end else begin
               n.sh   = pwdata[7:0];
            end
         end
      end

      // exchange engine: sixteen half periods, then one idle half
      if (r.xbusy) begin
         n.div = r.div + 8'h01;
         if (r.div == 8'(HALF_CYCLES - 1)) begin
            n.div = '0;
            if (r.hcnt == 5'(HALF_BITS)) begin
               n.xbusy = 1'b0;
            end else begin
               n.hcnt = r.hcnt + 5'd1;
               n.sclk = !r.sclk;
               if (!r.sclk) begin
                  n.rx = {r.rx[6:0], r.m2};
               end else begin
                  n.mosi = r.sh[7];
                  n.sh   = {r.sh[6:0], 1'b0};
               end
            end
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= HOST_RST;
      end else begin
         r <= n;
      end
   end

endmodule
`default_nettype wire

// >>> tb/sfsi_monitor.sv
// checker beside the link: pin relations and device activity flags
// assumes the link signals and the device's busy and standby as plain inputs
`timescale 1ns/1ps
`default_nettype none
module sfsi_monitor (
   // system
   input  wire logic pclk,
   input  wire logic presetn,
   // link pins
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic hold_n,
   input  wire logic miso_o,
   input  wire logic miso_oe,
   // device status
   input  wire logic standby,
   input  wire logic busy
);
   default clocking mon_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // deselect releases data out within the sync lag
   property p_desel_rel;
      cs_n [*5] |-> !miso_oe;
   endproperty
   a_desel_rel: assert property (p_desel_rel) else $error("data out driven while deselected");

   // pause with clock low releases data out
   property p_pause_rel;
      (!hold_n && !sclk) [*8] |-> !miso_oe;
   endproperty
   a_pause_rel: assert property (p_pause_rel) else $error("data out driven while paused");

   // driver turns on only when selected and not paused
   property p_oe_rise;
      $rose(miso_oe) |-> hold_n && !cs_n;
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("data out enabled out of frame");

   // no standby while an internal cycle runs
   property p_busy_act;
      busy |-> !standby;
   endproperty
   a_busy_act: assert property (p_busy_act) else $error("standby during internal cycle");

   // selected device is active
   property p_sel_act;
      (!cs_n) [*5] |-> !standby;
   endproperty
   a_sel_act: assert property (p_sel_act) else $error("standby while selected");

   // idle and deselected device drops to standby
   property p_idle_stby;
      (cs_n && !busy) [*5] |-> standby;
   endproperty
   a_idle_stby: assert property (p_idle_stby) else $error("no standby when idle");

   // internal cycles start only after select has risen
   property p_busy_start;
      $rose(busy) |-> cs_n && $past(cs_n, 2);
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("cycle started inside frame");

   // busy stands for at least eight clocks, half the shortest cycle
   property p_busy_hold;
      $rose(busy) |=> busy [*7];
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped too early");

   // data out moves only while the clock is low, after a fall
   property p_miso_fall;
      ($changed(miso_o) && miso_oe && $past(miso_oe) && !cs_n) |-> !sclk;
   endproperty
   a_miso_fall: assert property (p_miso_fall) else $error("data out changed with clock high");

   // master pauses only a selected device
   property p_pause_sel;
      !hold_n |-> !cs_n;
   endproperty
   a_pause_sel: assert property (p_pause_sel) else $error("pause while deselected");
endmodule
`default_nettype wire

// >>> tb/serial_flash_spi_interface_tb.sv
// bench: apb drives the host end, which talks to the device end over the link
// assumes package, link interface, both ends and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module serial_flash_spi_interface_tb;
   import sfsi_pkg::*;
   localparam int SE_N = 64;
   localparam int BE_N = 128;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, rxb, st, d;
   logic [31:0] pwdata, prdata, rd;
   logic        standby, busy, cpol, wp;
   logic [7:0]  mem [int];
   logic [7:0]  q [$];
   int          failures, total_checks, a, n, m, k, i;

   sfsi_link_if link ();
   sfsi_flash_dev #(.SE_LEN(SE_N), .BE_LEN(BE_N)) u_sfsi_flash_dev (.pclk(pclk),
      .presetn(presetn), .link(link), .standby(standby), .busy(busy));
   sfsi_spi_host u_sfsi_spi_host (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   sfsi_monitor u_sfsi_monitor (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
      .cs_n(link.cs_n), .hold_n(link.hold_n), .miso_o(link.miso_o),
      .miso_oe(link.miso_oe), .standby(standby), .busy(busy));

   // free-running bus clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // compare and count
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // control word: select, pause, idle level, protect pin
   task automatic ctl(input logic cs, input logic hold);
      apb(1'b1, REG_CTRL, {28'h0, wp, hold, cpol, cs});
   endtask

   // one byte each way, polling the host's busy flag
   task automatic xchg(input logic [7:0] b);
      apb(1'b1, REG_TX, {24'h0, b});
      do apb(1'b0, REG_STAT, 32'h0); while (rd[0] !== 1'b0);
      apb(1'b0, REG_RX, 32'h0);
      rxb = rd[7:0];
   endtask

   // whole frame of q; received bytes replace q
   task automatic frame();
      ctl(1'b1, 1'b0);
      foreach (q[j]) begin
         xchg(q[j]);
         q[j] = rxb;
      end
      ctl(1'b0, 1'b0);
      repeat (4) @(posedge pclk);
   endtask

   task automatic status();
      q = '{OPC_STATUS_READ, 8'h00};
      frame();
      st = q[1];
   endtask

   task automatic wait_idle();
      do status(); while (st[SR_BUSY] !== 1'b0);
   endtask

   task automatic write_enable_instr();
      q = '{OPC_WRITE_ENABLE};
      frame();
   endtask

   // instruction then address, msb first
   function automatic void hdr(input logic [7:0] op, input int ad);
      q = '{op, 8'(ad >> 16), 8'(ad >> 8), 8'(ad)};
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // watchdog well beyond the expected run
   initial begin
      repeat (90000) @(posedge pclk);
      failures++;
      conclude();
   end

   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cpol = 1'b0;
      wp = 1'b1;
      failures = 0;
      total_checks = 0;
      void'($urandom(79556));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("standby", 8'(standby), 8'h01);
      check("miso_rst", 8'(link.miso), 8'h01);
      apb(1'b0, 8'h10, 32'h0);
      check("slverr", 8'(err), 8'h01);
      apb(1'b0, REG_CTRL, 32'h0);
      check("ctrl_rst", rd[7:0], {4'h0, CTRL_RST});
      $display("reset test done");
      for (m = 0; m < 2; m++) begin
         cpol = m[0];
         ctl(1'b0, 1'b0);
         check("sclk_idle", 8'(link.sclk), 8'(cpol));
         write_enable_instr();
         status();
         check("wel_set", 8'(st[1:0]), 8'h02);
         q = '{OPC_WRITE_DISABLE};
         frame();
         status();
         check("wel_write_disable_instr", 8'(st[1:0]), 8'h00);
         // erase without write enable is dropped
         a = int'($urandom % SECTORS) * SECTOR_BYTES;
         hdr(OPC_SECTOR_CLEAR, a);
         frame();
         repeat (8) @(posedge pclk);
         check("no_erase", 8'(busy), 8'h00);
         write_enable_instr();
         hdr(OPC_SECTOR_CLEAR, a);
         frame();
         check("erase_busy", 8'(busy), 8'h01);
         check("erase_act", 8'(standby), 8'h00);
         wait_idle();
         check("wel_erase", 8'(st[SR_WEL]), 8'h00);
         for (i = 0; i < SE_N; i++) mem[a + i] = ERASED;
         // two programs on the same bytes only clear bits
         n = int'($urandom % (SE_N - 8));
         for (k = 0; k < 2; k++) begin
            write_enable_instr();
            hdr(OPC_PAGE_WRITE, a + n);
            for (i = 0; i < 8; i++) begin
               d = 8'($urandom);
               q.push_back(d);
               mem[a + n + i] = mem[a + n + i] & d;
            end
            frame();
            wait_idle();
         end
         hdr(OPC_READ, a);
         repeat (SE_N) q.push_back(8'h00);
         frame();
         for (i = 0; i < SE_N; i++) check("array", q[4 + i], mem[a + i]);
         // pause mid-read keeps the read position
         if (!cpol) begin
            hdr(OPC_READ, a + n);
            ctl(1'b1, 1'b0);
            foreach (q[j]) xchg(q[j]);
            xchg(8'h00);
            check("pre_pause", rxb, mem[a + n]);
            ctl(1'b1, 1'b1);
            repeat (20) @(posedge pclk);
            check("pause_rel", 8'(link.miso), 8'h01);
            check("pause_oe", 8'(link.miso_oe), 8'h00);
            check("pause_act", 8'(standby), 8'h00);
            ctl(1'b1, 1'b0);
            xchg(8'h00);
            check("post_pause", rxb, mem[a + n + 1]);
            ctl(1'b0, 1'b0);
         end
         $display("mode %0d test done", m);
      end
      // whole-array clear
      write_enable_instr();
      q = '{OPC_ARRAY_CLEAR};
      frame();
      wait_idle();
      hdr(OPC_READ, BE_N - 4);
      repeat (4) q.push_back(8'h00);
      frame();
      for (i = 0; i < 4; i++) check("bulk", q[4 + i], ERASED);
      $display("array clear test done");
      // protect bits frozen by the protect pin
      write_enable_instr();
      q = '{OPC_STATUS_WRITE, 8'h9C};
      frame();
      wait_idle();
      check("sr_set", st, 8'h9C);
      wp = 1'b0;
      write_enable_instr();
      q = '{OPC_STATUS_WRITE, 8'h00};
      frame();
      wait_idle();
      check("sr_frozen", 8'(st[7:2]), 8'h27);
      wp = 1'b1;
      write_enable_instr();
      q = '{OPC_STATUS_WRITE, 8'h00};
      frame();
      wait_idle();
      check("sr_clear", st, 8'h00);
      $display("status write test done");
      conclude();
   end
endmodule
`default_nettype wire
